// File: hdl/tpcr_top.v
/*
  thermal pin configuration register bank with axi4-lite slave,
  over-temperature comparison, pin drive and sticky interrupt status.
  assumes temperatures arrive synchronous to aclk from the measurement engines.
*/
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "tpcr_defs.vh"
module tpcr_top
(
  input wire aclk,
  input wire aresetn,
  input wire [8:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [8:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [7:0] local_temp,
  input wire [7:0] remote_one_temp,
  input wire [7:0] remote_two_temp,
  input wire overtemp_pin_in,
  output reg overtemp_pin_out,
  output reg overtemp_pin_oe_n,
  output reg [1:0] shared_pin_select,
  output reg temp_format_select,
  output reg fan_full_speed,
  output reg fan_max_speed,
  output reg cpu_supply_attenuator_bypass,
  output reg irq
);

  reg [7:0] thermal_pin_config_b;
  reg [7:0] pin_function_config_a;
  reg config_lock;
  reg [7:0] lim_loc;
  reg [7:0] lim_r1;
  reg [7:0] lim_r2;
  reg [3:0] irq_status;
  reg [3:0] irq_mask;
  reg [6:0] aw_idx;
  reg aw_full;
  reg [7:0] w_byte;
  reg w_lane0;
  reg w_full;
  reg [2:0] over_q;
  reg ext_q;
  reg [1:0] next_rresp;
  reg [31:0] next_rdata;

  wire [6:0] ar_idx = s_axi_araddr[8:2];
  wire twos = thermal_pin_config_b[`TPCR_B_FMT];
  wire global_off = pin_function_config_a[`TPCR_A_OFF];
  wire pin_is_ot = (pin_function_config_a[1:0] == `TPCR_PIN_OVERTEMP);
  wire do_write = aw_full && w_full && !s_axi_bvalid;
  wire wr_hit = do_write && w_lane0;

  // format-aware comparison of temperature against limit
  function above;
    input [7:0] t;
    input [7:0] lim;
    input tc;
    begin
      if (tc)
        above = ($signed(t) > $signed(lim));
      else
        above = (t > lim);
    end
  endfunction

  // limit at the coding's floor switches the channel off
  function lim_off;
    input [7:0] lim;
    input tc;
    begin
      lim_off = tc ? (lim == `TPCR_TWOS_DIS) : (lim == `TPCR_OFF64_DIS);
    end
  endfunction

  function known_idx;
    input [6:0] idx;
    begin
      case (idx)
        `TPCR_IDX_CFG_B, `TPCR_IDX_CFG_A, `TPCR_IDX_TEST1, `TPCR_IDX_TEST2,
        `TPCR_IDX_LOCK, `TPCR_IDX_LIM_LOC, `TPCR_IDX_LIM_R1, `TPCR_IDX_LIM_R2,
        `TPCR_IDX_STATUS, `TPCR_IDX_MASK, `TPCR_IDX_LIVE:
          known_idx = 1'b1;
        default:
          known_idx = 1'b0;
      endcase
    end
  endfunction

  // per-channel over-temperature condition
  wire ch_loc = thermal_pin_config_b[`TPCR_B_LOC] && !lim_off(lim_loc, twos)
    && above(local_temp, lim_loc, twos);
  wire ch_r1 = thermal_pin_config_b[`TPCR_B_R1] && !lim_off(lim_r1, twos)
    && above(remote_one_temp, lim_r1, twos);
  wire ch_r2 = thermal_pin_config_b[`TPCR_B_R2] && !lim_off(lim_r2, twos)
    && above(remote_two_temp, lim_r2, twos);
  wire [2:0] over_now = global_off ? 3'b000 : {ch_r2, ch_r1, ch_loc};
  wire over_any = |over_now;
  wire drive_pin = over_any && pin_is_ot;
  // external party pulling the pin low while we are not driving it
  wire ext_now = pin_is_ot && !global_off && !overtemp_pin_in && overtemp_pin_oe_n;
  wire [3:0] events = {ext_now && !ext_q, over_now & ~over_q};

  // write address and data channels, taken in either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TPCR_RESP_OKAY;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_idx <= 7'h00;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_idx <= s_axi_awaddr[8:2];
        aw_full <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_byte <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
        w_full <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= known_idx(aw_idx) ? `TPCR_RESP_OKAY : `TPCR_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // register file writes
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      thermal_pin_config_b <= `TPCR_CFG_RST;
      pin_function_config_a <= `TPCR_CFG_RST;
      config_lock <= 1'b0;
      lim_loc <= `TPCR_LIM_RST;
      lim_r1 <= `TPCR_LIM_RST;
      lim_r2 <= `TPCR_LIM_RST;
      irq_mask <= 4'h0;
    end
    else if (wr_hit)
    begin
      case (aw_idx)
        `TPCR_IDX_CFG_B:
          if (!config_lock)
            thermal_pin_config_b <= w_byte & `TPCR_CFG_B_MASK;
        `TPCR_IDX_CFG_A:
          if (!config_lock)
            pin_function_config_a <= w_byte & `TPCR_CFG_A_MASK;
        `TPCR_IDX_LOCK:
          config_lock <= config_lock | w_byte[0];
        `TPCR_IDX_LIM_LOC:
          lim_loc <= w_byte;
        `TPCR_IDX_LIM_R1:
          lim_r1 <= w_byte;
        `TPCR_IDX_LIM_R2:
          lim_r2 <= w_byte;
        `TPCR_IDX_MASK:
          irq_mask <= w_byte[3:0];
        default:
          irq_mask <= irq_mask; // test registers and unmapped: no store
      endcase
    end
  end

  // sticky status: an event in the clearing cycle survives
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_status <= 4'h0;
      over_q <= 3'b000;
      ext_q <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      over_q <= over_now;
      ext_q <= ext_now;
      if (wr_hit && aw_idx == `TPCR_IDX_STATUS)
        irq_status <= (irq_status & ~w_byte[3:0]) | events;
      else
        irq_status <= irq_status | events;
      irq <= |(irq_status & irq_mask);
    end
  end

  // read data mux
  always @*
  begin
    next_rdata = 32'h0000_0000;
    next_rresp = `TPCR_RESP_OKAY;
    case (ar_idx)
      `TPCR_IDX_CFG_B:
        next_rdata[7:0] = thermal_pin_config_b;
      `TPCR_IDX_CFG_A:
        next_rdata[7:0] = pin_function_config_a;
      `TPCR_IDX_TEST1:
        next_rdata[7:0] = `TPCR_TEST_RST;
      `TPCR_IDX_TEST2:
        next_rdata[7:0] = `TPCR_TEST_RST;
      `TPCR_IDX_LOCK:
        next_rdata[0] = config_lock;
      `TPCR_IDX_LIM_LOC:
        next_rdata[7:0] = lim_loc;
      `TPCR_IDX_LIM_R1:
        next_rdata[7:0] = lim_r1;
      `TPCR_IDX_LIM_R2:
        next_rdata[7:0] = lim_r2;
      `TPCR_IDX_STATUS:
        next_rdata[3:0] = irq_status;
      `TPCR_IDX_MASK:
        next_rdata[3:0] = irq_mask;
      `TPCR_IDX_LIVE:
        next_rdata[4:0] = {!overtemp_pin_in, 1'b0, over_now};
      default:
        next_rresp = `TPCR_RESP_SLVERR;
    endcase
  end

  // read channel
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `TPCR_RESP_OKAY;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= next_rresp;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // pin drive and fan/config outputs
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      overtemp_pin_out <= 1'b1;
      overtemp_pin_oe_n <= 1'b1;
      shared_pin_select <= `TPCR_PIN_TACHO;
      temp_format_select <= 1'b0;
      fan_full_speed <= 1'b0;
      fan_max_speed <= 1'b0;
      cpu_supply_attenuator_bypass <= 1'b0;
    end
    else
    begin
      overtemp_pin_out <= !drive_pin;
      overtemp_pin_oe_n <= !drive_pin;
      shared_pin_select <= pin_function_config_a[1:0];
      temp_format_select <= twos;
      fan_full_speed <= over_any && !pin_function_config_a[`TPCR_A_SPD];
      fan_max_speed <= over_any && pin_function_config_a[`TPCR_A_SPD];
      cpu_supply_attenuator_bypass <= pin_function_config_a[`TPCR_A_BYP];
    end
  end

endmodule

// File: shared/tpcr_defs.vh
// What this block does
// - local limit enable set applies local over-temperature limit and drives the pin.
// - remote two limit enable set applies its limit and drives the pin.
// - offset-64 mode: a limit of minus 64 degrees disables that channel.
// - twos complement mode: a limit of minus 128 degrees disables that channel.
// - two-bit field picks shared pin role: tacho, over-temp, alert, gpio.
// - global off bit kills the whole over-temperature feature.
// - over-temperature sends fans to full speed, or to programmed maximum when set.
// - bypass bit switches the cpu supply channel to its unattenuated scale.
// - lock bit makes both configuration registers read-only.
// - both configuration and both test registers reset to zero.
// - remote one limit enable set applies its limit and drives the pin.
// - format bit picks twos complement or offset-64 temperature coding.
/*
  constants of the thermal pin configuration register bank.
  assumes byte address = 4 * register index on a 32-bit axi4-lite bus.
*/
`ifndef TPCR_DEFS_VH
`define TPCR_DEFS_VH
`define TPCR_IDX_CFG_B 7'h7c
`define TPCR_IDX_CFG_A 7'h7d
`define TPCR_IDX_TEST1 7'h7e
`define TPCR_IDX_TEST2 7'h7f
`define TPCR_IDX_LOCK 7'h00
`define TPCR_IDX_LIM_LOC 7'h01
`define TPCR_IDX_LIM_R1 7'h02
`define TPCR_IDX_LIM_R2 7'h03
`define TPCR_IDX_STATUS 7'h04
`define TPCR_IDX_MASK 7'h05
`define TPCR_IDX_LIVE 7'h06
`define TPCR_CFG_RST 8'h00
`define TPCR_TEST_RST 8'h00
`define TPCR_LIM_RST 8'h7f
`define TPCR_CFG_B_MASK 8'hef
`define TPCR_CFG_A_MASK 8'h4f
`define TPCR_B_FMT 0
`define TPCR_B_R1 5
`define TPCR_B_LOC 6
`define TPCR_B_R2 7
`define TPCR_A_OFF 2
`define TPCR_A_SPD 3
`define TPCR_A_BYP 6
`define TPCR_PIN_TACHO 2'b00
`define TPCR_PIN_OVERTEMP 2'b01
`define TPCR_PIN_ALERT 2'b10
`define TPCR_PIN_GPIO 2'b11
`define TPCR_OFF64_DIS 8'h00
`define TPCR_TWOS_DIS 8'h80
`define TPCR_RESP_OKAY 2'b00
`define TPCR_RESP_SLVERR 2'b10
`endif

// File: sim/tpcr_bench.sv
/* self-checking bench for tpcr_top.
   assumes tpcr_chk is bound to the design and a pull-up on the pin. */
`timescale 1ns/1ps
`include "tpcr_defs.vh"
module thermal_pin_config_regs_bench;
  reg aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  reg s_axi_arvalid = 0, s_axi_rready = 0;
  reg [8:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  reg [31:0] s_axi_wdata = 0, rv;
  reg [7:0] local_temp = 0, remote_one_temp = 0, remote_two_temp = 0;
  reg [1:0] rs;
  reg ext_pull = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  wire overtemp_pin_out, overtemp_pin_oe_n, fan_full_speed, fan_max_speed;
  wire cpu_supply_attenuator_bypass, temp_format_select;
  wire [1:0] s_axi_bresp, s_axi_rresp, shared_pin_select;
  wire [31:0] s_axi_rdata;
  wire pin = (overtemp_pin_oe_n ? 1'b1 : overtemp_pin_out) & !ext_pull;
  integer seed = 63040, err_total = 0, check_count = 0, i;
  tpcr_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .local_temp, .remote_one_temp, .remote_two_temp, .overtemp_pin_in(pin),
    .overtemp_pin_out, .overtemp_pin_oe_n, .shared_pin_select, .temp_format_select,
    .fan_full_speed, .fan_max_speed, .cpu_supply_attenuator_bypass, .irq);
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task check(input string n, input [31:0] e, input [31:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e)
      begin
        err_total = err_total + 1;
        $display("[FAIL] %0s expected %h seen %h", n, e, g);
      end
    end
  endtask
  task wr(input [8:0] a, input [7:0] d);
    reg aw, w;
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      aw = 1;
      w = 1;
      while (aw || w)
      begin
        @(posedge aclk);
        aw = aw && !s_axi_awready;
        w = w && !s_axi_wready;
        s_axi_awvalid <= aw;
        s_axi_wvalid <= w;
      end
      while (!s_axi_bvalid) @(posedge aclk);
      s_axi_bready <= 1'b0;
      rs = s_axi_bresp;
    end
  endtask
  task rd(input [8:0] a);
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      while (!s_axi_arready) @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      while (!s_axi_rvalid) @(posedge aclk);
      s_axi_rready <= 1'b0;
      rv = s_axi_rdata;
      rs = s_axi_rresp;
    end
  endtask
  function ovr(input [7:0] t, input [7:0] l, input en, input tc);
    ovr = en && l != (tc ? 8'h80 : 8'h00) && (tc ? $signed(t) > $signed(l) : t > l);
  endfunction
  task tcase(input [7:0] cb, ca, l0, l1, l2, x0, x1, x2);
    reg act;
    begin
      wr(9'h1f0, cb);
      wr(9'h1f4, ca);
      wr(9'h004, l0);
      wr(9'h008, l1);
      wr(9'h00c, l2);
      local_temp <= x0;
      remote_one_temp <= x1;
      remote_two_temp <= x2;
      repeat (4) @(posedge aclk);
      act = (ovr(x0, l0, cb[6], cb[0]) | ovr(x1, l1, cb[5], cb[0]) | ovr(x2, l2, cb[7], cb[0]))
        & !ca[2];
      check("fans", {act & !ca[3], act & ca[3]}, {fan_full_speed, fan_max_speed});
      check("pin", {2{!(act && ca[1:0] == 2'b01)}}, {overtemp_pin_oe_n, overtemp_pin_out});
      check("cfg outs", {ca[6], cb[0], ca[1:0]}, {cpu_supply_attenuator_bypass,
        temp_format_select, shared_pin_select});
      rd(9'h1f0);
      check("cfg_b", cb & `TPCR_CFG_B_MASK, rv);
      rd(9'h1f4);
      check("cfg_a", ca & `TPCR_CFG_A_MASK, rv);
    end
  endtask
  initial forever #2 aclk = ~aclk;
  initial
  begin
    #60000 err_total = err_total + 1;
    complete_run;
  end
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 4; i = i + 1)
    begin
      rd(9'h1f0 + 4 * i);
      check("reset value", 32'h0, rv);
    end
    rd(9'h1fc);
    check("test reg", 32'h0, rv); // host never writes it
    rd(9'h100);
    check("unmapped", 2'b10, rs);
    wr(9'h100, 8'h00);
    check("unmapped wr", 2'b10, rs);
    wr(9'h1f4, 8'h00);
    check("cfg_a wr resp", 2'b00, rs);
    tcase(8'h40, 8'h01, 8'h50, 8'h7f, 8'h7f, 8'h60, 8'h00, 8'h00);
    tcase(8'h40, 8'h09, 8'h50, 8'h7f, 8'h7f, 8'h60, 8'h00, 8'h00);
    tcase(8'h40, 8'h05, 8'h50, 8'h7f, 8'h7f, 8'h60, 8'h00, 8'h00);
    tcase(8'h40, 8'h01, 8'h00, 8'h7f, 8'h7f, 8'h60, 8'h00, 8'h00);
    tcase(8'h41, 8'h01, 8'h80, 8'h7f, 8'h7f, 8'h10, 8'h00, 8'h00);
    tcase(8'h41, 8'h42, 8'hf0, 8'h7f, 8'h7f, 8'h10, 8'h00, 8'h00);
    tcase(8'h20, 8'h01, 8'h00, 8'h50, 8'h7f, 8'h00, 8'h51, 8'h00);
    tcase(8'h80, 8'h03, 8'h00, 8'h7f, 8'h50, 8'h00, 8'h00, 8'h60);
    tcase(8'h10, 8'h01, 8'h50, 8'h50, 8'h50, 8'h60, 8'h60, 8'h60);
    for (i = 0; i < 12; i = i + 1)
      tcase($random(seed), $random(seed), $random(seed), $random(seed), $random(seed),
        $random(seed), $random(seed), $random(seed));
    tcase(8'h40, 8'h01, 8'h50, 8'h7f, 8'h7f, 8'h10, 8'h00, 8'h00);
    wr(9'h010, 8'h0f);
    wr(9'h014, 8'h01);
    local_temp <= 8'h60;
    repeat (4) @(posedge aclk);
    check("irq set", 1'b1, irq);
    rd(9'h010);
    check("status", 32'h1, rv);
    wr(9'h014, 8'h00);
    repeat (3) @(posedge aclk);
    check("irq masked", 1'b0, irq);
    wr(9'h014, 8'h01);
    wr(9'h010, 8'h01);
    repeat (3) @(posedge aclk);
    check("irq cleared", 1'b0, irq);
    local_temp <= 8'h10;
    ext_pull <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(9'h018);
    check("live", 32'h10, rv);
    rd(9'h010);
    check("ext status", 32'h8, rv);
    ext_pull <= 1'b0;
    wr(9'h000, 8'h01);
    wr(9'h1f0, 8'h0f);
    rd(9'h1f0);
    check("locked cfg_b", 32'h40, rv);
    wr(9'h1f4, 8'h00);
    rd(9'h1f4);
    check("locked cfg_a", 32'h01, rv);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(9'h1f0);
    check("second reset", 32'h0, rv);
    complete_run;
  end
endmodule

// File: sim/tpcr_chk.sv
/* port checker for tpcr_top.
   assumes it is bound to every tpcr_top instance. */
`timescale 1ns/1ps
module tpcr_chk
(
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire overtemp_pin_out,
  input wire overtemp_pin_oe_n,
  input wire [1:0] shared_pin_select,
  input wire fan_full_speed,
  input wire fan_max_speed
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_fan_onehot: assert property (!(fan_full_speed && fan_max_speed))
    else $error("both fan speeds requested");
  chk_pin_level: assert property (!overtemp_pin_oe_n |-> !overtemp_pin_out)
    else $error("pin driven high");
  chk_pin_role: assert property (!overtemp_pin_oe_n |-> shared_pin_select == 2'b01)
    else $error("pin driven in wrong role");
  chk_pin_fans: assert property (!overtemp_pin_oe_n |-> fan_full_speed || fan_max_speed)
    else $error("pin asserted without fan boost");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_w_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
  chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (!overtemp_pin_oe_n);
  cover property (fan_max_speed);
endmodule
bind tpcr_top tpcr_chk chk_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .overtemp_pin_out, .overtemp_pin_oe_n,
  .shared_pin_select, .fan_full_speed, .fan_max_speed);
